// ---- esp_pkg.sv ----
// Shared constants and types for the enhanced serial port
package esp_pkg;
	// Mode codes, {mode_select_high, mode_select_low}
	localparam logic [1:0] ESP_MODE0 = 2'h0;
	localparam logic [1:0] ESP_MODE1 = 2'h1;
	localparam logic [1:0] ESP_MODE2 = 2'h2;
	localparam logic [1:0] ESP_MODE3 = 2'h3;
	// Bit timing
	localparam logic [3:0] ESP_M0_CLKS = 4'hc;
	localparam logic [3:0] ESP_M0_HALF = 4'h6;
	localparam logic [3:0] ESP_OVS_LAST = 4'hf;
	localparam logic [3:0] ESP_MID = 4'h7;
	localparam logic [1:0] ESP_M2_FAST_LAST = 2'h1;
	localparam logic [1:0] ESP_M2_SLOW_LAST = 2'h3;
	// Frame lengths in bits
	localparam logic [3:0] ESP_BITS_M0 = 4'h8;
	localparam logic [3:0] ESP_BITS_10 = 4'ha;
	localparam logic [3:0] ESP_BITS_11 = 4'hb;
	// Reset values and receive buffer depth
	localparam logic ESP_RST_SEL_LOW = 1'h0;
	localparam logic ESP_RST_LINE = 1'h1;
	localparam int ESP_FIFO_DEPTH = 2;
	typedef struct packed {
		logic b9;
		logic [7:0] data;
	} esp_word_t;
	typedef enum logic [1:0] {
		ESP_IDLE = 2'b00,
		ESP_RUN = 2'b01,
		ESP_HOLD = 2'b10
	} esp_st_t;
endpackage

// ---- esp_serial_port.sv ----
// Enhanced serial port: four modes, frame error, address recognition
`timescale 1ns/10ps
module esp_serial_port #(
	parameter int DEPTH = esp_pkg::ESP_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic mode_select_high,
	input wire logic address_filter_enable,
	input wire logic rx_enable,
	input wire logic double_rate,
	input wire logic bit7_view_select,
	input wire logic bit7_wr,
	input wire logic bit7_wdata,
	input wire logic serial_buffer_wr,
	input wire esp_pkg::esp_word_t tx_word,
	input wire logic serial_buffer_rd,
	input wire logic ri_clr,
	input wire logic ti_clr,
	input wire logic serial_int_en,
	input wire logic timer1_ovf,
	input wire logic timer2_ovf,
	input wire logic timer2_rx_baud_select,
	input wire logic timer2_tx_baud_select,
	input wire logic [7:0] slave_match_value,
	input wire logic [7:0] slave_match_mask,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd,
	output esp_pkg::esp_word_t rx_word,
	output logic rx_valid,
	output logic receive_complete_flag,
	output logic transmit_complete_flag,
	output logic serial_irq,
	output logic shared_bit7_position,
	output logic timer2_flag_block
);
	import esp_pkg::*;

	// Given address on masked bits, or broadcast on set bits
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] v,
		input logic [7:0] m);
		logic [7:0] bc;
		bc = v | m;
		addr_hit = (((a ^ v) & m) == 8'h0) || (((a ^ bc) & bc) == 8'h0);
	endfunction

	logic [1:0] mode;
	logic sel_low_r, sel_low_nxt, fe_r, fe_nxt, ri_r, ri_nxt, ti_r, ti_nxt;
	logic irq_r, irq_nxt, bit7_r, bit7_nxt, t2blk_r, t2blk_nxt;
	logic [1:0] pre_r, pre_nxt;
	logic t1_half_r, t1_half_nxt, m2_tick, t1_tick, rx_tick, tx_tick;
	esp_st_t tx_st_r, tx_st_nxt, rx_st_r, rx_st_nxt;
	logic [10:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
	logic [3:0] tx_cnt_r, tx_cnt_nxt, tx_ph_r, tx_ph_nxt, rx_cnt_r, rx_cnt_nxt;
	logic [3:0] rx_ph_r, rx_ph_nxt, tx_len, rx_len;
	logic m0_rx_r, m0_rx_nxt, txd_r, txd_nxt, rxd_out_r, rxd_out_nxt;
	logic rxd_oe_r, rxd_oe_nxt, tx_done, m0_push, rx_push, rx_done, rx_acc;
	logic push_v, push_ok, pop, fifo_in_rdy;
	esp_word_t push_w;
	esp_word_t mem_r [DEPTH];
	esp_word_t mem_nxt [DEPTH];
	logic [DEPTH-1:0] v_r, v_nxt;

	assign mode = {mode_select_high, sel_low_r};
	assign tx_len = (mode == ESP_MODE1) ? ESP_BITS_10 : ESP_BITS_11;
	assign rx_len = tx_len;

	////////////////////////////////////////////////////////////////////////
	// Baud ticks, 16 per bit in the async modes
	always_comb begin
		m2_tick = (pre_r == (double_rate ? ESP_M2_FAST_LAST : ESP_M2_SLOW_LAST));
		pre_nxt = m2_tick ? 2'h0 : pre_r + 2'h1;
		t1_half_nxt = timer1_ovf ? !t1_half_r : t1_half_r;
		t1_tick = timer1_ovf && (double_rate || t1_half_r);
		// Timer 2 runs at 16x already, so it skips the halving
		rx_tick = (mode == ESP_MODE2) ? m2_tick :
			(timer2_rx_baud_select ? timer2_ovf : t1_tick);
		tx_tick = (mode == ESP_MODE2) ? m2_tick :
			(timer2_tx_baud_select ? timer2_ovf : t1_tick);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre_r <= 2'h0;
			t1_half_r <= 1'h0;
		end else begin
			pre_r <= pre_nxt;
			t1_half_r <= t1_half_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit engine; in mode 0 it also runs the half-duplex receive
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_sh_nxt = tx_sh_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_ph_nxt = tx_ph_r;
		m0_rx_nxt = m0_rx_r;
		txd_nxt = txd_r;
		rxd_out_nxt = rxd_out_r;
		rxd_oe_nxt = rxd_oe_r;
		tx_done = 1'b0;
		m0_push = 1'b0;
		unique case (tx_st_r)
			ESP_IDLE: begin
				txd_nxt = ESP_RST_LINE;
				rxd_oe_nxt = 1'b0;
				tx_ph_nxt = 4'h0;
				tx_cnt_nxt = 4'h0;
				if (serial_buffer_wr) begin
					tx_st_nxt = ESP_RUN;
					m0_rx_nxt = 1'b0;
					txd_nxt = 1'b0;
					if (mode == ESP_MODE0) begin
						tx_sh_nxt = {3'h7, tx_word.data};
						rxd_oe_nxt = 1'b1;
						rxd_out_nxt = tx_word.data[0];
					end else begin
						// Mode 1 puts the stop bit where the ninth bit sits
						tx_sh_nxt = {1'b1, (mode == ESP_MODE1) | tx_word.b9,
							tx_word.data, 1'b0};
					end
				end else if (mode == ESP_MODE0 && rx_enable && !ri_r && fifo_in_rdy) begin
					tx_st_nxt = ESP_RUN;
					m0_rx_nxt = 1'b1;
					txd_nxt = 1'b0;
				end
			end
			ESP_RUN: begin
				if (mode == ESP_MODE0) begin
					tx_ph_nxt = (tx_ph_r == ESP_M0_CLKS - 4'h1) ? 4'h0 : tx_ph_r + 4'h1;
					txd_nxt = (tx_ph_nxt >= ESP_M0_HALF);
					if (tx_ph_r == ESP_M0_CLKS - 4'h1) begin
						tx_cnt_nxt = tx_cnt_r + 4'h1;
						if (m0_rx_r) begin
							tx_sh_nxt[7:0] = {rxd_in, tx_sh_r[7:1]};
						end else begin
							tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
							rxd_out_nxt = tx_sh_r[1];
						end
						if (tx_cnt_r == ESP_BITS_M0 - 4'h1) begin
							tx_done = 1'b1;
							tx_st_nxt = ESP_IDLE;
							txd_nxt = ESP_RST_LINE;
							rxd_oe_nxt = 1'b0;
							m0_push = m0_rx_r;
						end
					end
				end else if (tx_tick) begin
					tx_ph_nxt = tx_ph_r + 4'h1;
					if (tx_ph_r == ESP_OVS_LAST) begin
						tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
						txd_nxt = tx_sh_r[1];
						tx_cnt_nxt = tx_cnt_r + 4'h1;
						if (tx_cnt_r == tx_len - 4'h1) begin
							tx_done = 1'b1;
							tx_st_nxt = ESP_IDLE;
						end
					end
				end
			end
			default: tx_st_nxt = ESP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_st_r <= ESP_IDLE;
			tx_sh_r <= 11'h7ff;
			tx_cnt_r <= 4'h0;
			tx_ph_r <= 4'h0;
			m0_rx_r <= 1'b0;
			txd_r <= ESP_RST_LINE;
			rxd_out_r <= ESP_RST_LINE;
			rxd_oe_r <= 1'b0;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_ph_r <= tx_ph_nxt;
			m0_rx_r <= m0_rx_nxt;
			txd_r <= txd_nxt;
			rxd_out_r <= rxd_out_nxt;
			rxd_oe_r <= rxd_oe_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Async receive engine, mid-bit sampling; holds the word while full
	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_sh_nxt = rx_sh_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_ph_nxt = rx_ph_r;
		rx_done = 1'b0;
		rx_push = 1'b0;
		// Bit 9 is the stop bit in mode 1, the ninth data bit otherwise
		rx_acc = !address_filter_enable || ((mode == ESP_MODE1) ? rx_sh_r[9] :
			(rx_sh_r[9] && addr_hit(rx_sh_r[8:1], slave_match_value,
			slave_match_mask)));
		unique case (rx_st_r)
			ESP_IDLE: begin
				rx_ph_nxt = 4'h0;
				rx_cnt_nxt = 4'h0;
				if (mode != ESP_MODE0 && rx_enable && rx_tick && !rxd_in) begin
					rx_st_nxt = ESP_RUN;
				end
			end
			ESP_RUN: begin
				if (mode == ESP_MODE0) begin
					rx_st_nxt = ESP_IDLE;
				end else if (rx_tick) begin
					rx_ph_nxt = rx_ph_r + 4'h1;
					if (rx_ph_r == ESP_MID) begin
						rx_sh_nxt[rx_cnt_r] = rxd_in;
						rx_cnt_nxt = rx_cnt_r + 4'h1;
						if (rx_cnt_r == 4'h0 && rxd_in) begin
							rx_st_nxt = ESP_IDLE; // Glitch, not a start bit
						end else if (rx_cnt_r == rx_len - 4'h1) begin
							rx_done = 1'b1;
							rx_st_nxt = ESP_HOLD;
						end
					end
				end
			end
			ESP_HOLD: begin
				// Waiting here instead of dropping keeps a full buffer lossless
				if (!rx_acc) begin
					rx_st_nxt = ESP_IDLE;
				end else if (fifo_in_rdy) begin
					rx_push = 1'b1;
					rx_st_nxt = ESP_IDLE;
				end
			end
			default: rx_st_nxt = ESP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_st_r <= ESP_IDLE;
			rx_sh_r <= 11'h0;
			rx_cnt_r <= 4'h0;
			rx_ph_r <= 4'h0;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_ph_r <= rx_ph_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive buffer, shift style so the head is always entry 0
	assign push_v = rx_push | m0_push;
	assign push_w = m0_push ? {1'b0, rxd_in, tx_sh_r[7:1]} : {rx_sh_r[9], rx_sh_r[8:1]};
	assign fifo_in_rdy = !v_r[DEPTH-1];
	assign push_ok = push_v && fifo_in_rdy;
	assign pop = serial_buffer_rd && v_r[0];

	always_comb begin
		logic placed;
		placed = 1'b0;
		mem_nxt = mem_r;
		v_nxt = v_r;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				mem_nxt[i] = mem_r[i+1];
				v_nxt[i] = v_r[i+1];
			end
			v_nxt[DEPTH-1] = 1'b0;
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (push_ok && !placed && !v_nxt[i]) begin
				mem_nxt[i] = push_w;
				v_nxt[i] = 1'b1;
				placed = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			v_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			v_r <= v_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags and the shared bit 7; hardware set wins over a clear
	always_comb begin
		sel_low_nxt = (bit7_wr && !bit7_view_select) ? bit7_wdata : sel_low_r;
		fe_nxt = fe_r;
		if (rx_done && !rxd_in) begin
			fe_nxt = 1'b1;
		end else if (bit7_wr && bit7_view_select && !bit7_wdata) begin
			fe_nxt = 1'b0;
		end
		ri_nxt = push_ok ? 1'b1 : (ri_clr ? 1'b0 : ri_r);
		ti_nxt = (tx_done && !m0_rx_r) ? 1'b1 : (ti_clr ? 1'b0 : ti_r);
		irq_nxt = serial_int_en && (ri_nxt || ti_nxt);
		bit7_nxt = bit7_view_select ? fe_nxt : sel_low_nxt;
		t2blk_nxt = timer2_rx_baud_select || timer2_tx_baud_select;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_low_r <= ESP_RST_SEL_LOW;
			fe_r <= 1'b0;
			ri_r <= 1'b0;
			ti_r <= 1'b0;
			irq_r <= 1'b0;
			bit7_r <= 1'b0;
			t2blk_r <= 1'b0;
		end else begin
			sel_low_r <= sel_low_nxt;
			fe_r <= fe_nxt;
			ri_r <= ri_nxt;
			ti_r <= ti_nxt;
			irq_r <= irq_nxt;
			bit7_r <= bit7_nxt;
			t2blk_r <= t2blk_nxt;
		end
	end

	assign rxd_out = rxd_out_r;
	assign rxd_oe = rxd_oe_r;
	assign txd = txd_r;
	assign rx_word = mem_r[0];
	assign rx_valid = v_r[0];
	assign receive_complete_flag = ri_r;
	assign transmit_complete_flag = ti_r;
	assign serial_irq = irq_r;
	assign shared_bit7_position = bit7_r;
	assign timer2_flag_block = t2blk_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_clk_low;
		!txd_r [*6];
	endsequence
	sequence s_clk_high;
		txd_r [*6];
	endsequence
	property p_m0_clock;
		@(posedge clk) disable iff (!nrst)
		(tx_st_r == ESP_RUN && mode == ESP_MODE0 && tx_ph_r == 4'h0 && $stable(mode))
		|-> s_clk_low ##1 s_clk_high;
	endproperty
	a_m0_clock: assert property (p_m0_clock) else $error("mode 0 clock not 12");

	property p_fe_set;
		@(posedge clk) disable iff (!nrst) (rx_done && !rxd_in) |=> fe_r;
	endproperty
	a_fe_set: assert property (p_fe_set) else $error("frame error missed");

	property p_fe_sticky;
		@(posedge clk) disable iff (!nrst)
		(fe_r && !(bit7_wr && bit7_view_select)) |=> fe_r;
	endproperty
	a_fe_sticky: assert property (p_fe_sticky) else $error("frame error lost");

	property p_view;
		@(posedge clk) disable iff (!nrst)
		##1 (shared_bit7_position == ($past(bit7_view_select) ? fe_r : sel_low_r));
	endproperty
	a_view: assert property (p_view) else $error("bit 7 view wrong");

	property p_filter;
		@(posedge clk) disable iff (!nrst)
		(rx_st_r == ESP_HOLD && address_filter_enable && mode[1] &&
		!(rx_sh_r[9] && addr_hit(rx_sh_r[8:1], slave_match_value, slave_match_mask)))
		|-> !rx_push ##1 (rx_st_r == ESP_IDLE);
	endproperty
	a_filter: assert property (p_filter) else $error("unmatched address taken");

	property p_nofilter;
		@(posedge clk) disable iff (!nrst)
		(rx_st_r == ESP_HOLD && !address_filter_enable && fifo_in_rdy) |=> ri_r;
	endproperty
	a_nofilter: assert property (p_nofilter) else $error("frame not flagged");

	property p_ti;
		@(posedge clk) disable iff (!nrst) (tx_done && !m0_rx_r) |=> ti_r ##1 (ti_r || $past(ti_clr));
	endproperty
	a_ti: assert property (p_ti) else $error("transmit flag missing");

	property p_load;
		@(posedge clk) disable iff (!nrst)
		(serial_buffer_wr && tx_st_r == ESP_IDLE && mode != ESP_MODE0)
		|=> (tx_sh_r[8:1] == $past(tx_word.data)) && !tx_sh_r[0] && !txd_r;
	endproperty
	a_load: assert property (p_load) else $error("transmit load wrong");

	property p_t2;
		@(posedge clk) disable iff (!nrst)
		(timer2_rx_baud_select || timer2_tx_baud_select) |=> timer2_flag_block;
	endproperty
	a_t2: assert property (p_t2) else $error("timer 2 flag not blocked");
endmodule // esp_serial_port

// ---- esp_far_end.sv ----
// Far-end serial node: sends async frames to the port, decodes its output
`timescale 1ns/10ps
module esp_far_end (
	clk,
	txd,
	rxd_out,
	rxd_oe,
	line
);
	input wire logic clk;
	input wire logic txd;
	input wire logic rxd_out;
	input wire logic rxd_oe;
	output logic line;
	logic [9:0] got;
	int seen = 0;
	int bit_clks = 16;
	logic m0 = 1'h0;
	logic [7:0] m0_got = 8'h00, m0_out = 8'h00;
	int m0_left = 0;
	// Mode 0: take the data pin on the rising shift clock while it is driven
	always @(posedge txd) begin
		if (rxd_oe) m0_got = {rxd_out, m0_got[7:1]};
	end
	// Mode 0: next bit goes out as the shift clock falls
	always @(negedge txd) begin
		if (m0 && m0_left > 0) begin
			line = m0_out[0];
			m0_out = {1'h1, m0_out[7:1]};
			m0_left--;
		end
	end
	// Line rests high between frames, as a pulled-up line does
	initial line = 1'h1;
	////////////////////////////////////////////////////////////////
	// Start, eight data bits LSB first, ninth bit, chosen stop level
	task automatic send(input logic [8:0] w, input logic stp);
		logic [10:0] f;
		f = {stp, w, 1'h0};
		for (int i = 0; i < 11; i++) begin
			line = f[i];
			repeat (bit_clks) @(negedge clk);
		end
		line = 1'h1;
	endtask
	////////////////////////////////////////////////////////////////
	// Decoder samples mid-bit; the extra bit in 10-bit mode reads idle high
	always begin
		@(negedge txd);
		// In mode 0 the line is a shift clock, not a frame
		if (!m0) begin
			repeat (bit_clks / 2) @(posedge clk);
			for (int i = 0; i < 10; i++) begin
				repeat (bit_clks) @(posedge clk);
				got[i] = txd;
			end
			seen++;
		end
	end
endmodule // esp_far_end

// ---- esp_serial_port_tb_top.sv ----
// Self-checking bench for the enhanced serial port
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module esp_serial_port_tb_top;
	import esp_pkg::*;
	logic clk = 1'h0, nrst = 1'h0, msh = 1'h0, afe = 1'h0, rx_en = 1'h0, dbl = 1'h0;
	logic view = 1'h0, b7wr = 1'h0, b7d = 1'h0, sb_wr = 1'h0, serial_buffer_rd = 1'h0;
	logic ri_clr = 1'h0, ti_clr = 1'h0, t2rx = 1'h1, t2tx = 1'h1, rd_en = 1'h1;
	logic [7:0] smv = 8'h00, smm = 8'h00;
	logic [15:0] lfsr = 16'h5c61;
	esp_word_t tx_word = '0, rx_word, e;
	logic [9:0] e10;
	logic rxd_in, rxd_out, rxd_oe, txd, rx_valid, ri, ti, irq, b7, t2blk;
	int num_errors = 0, check_count = 0;
	esp_word_t rxq[$];
	logic [9:0] txq[$];
	// Half period of 2.5 ns gives 200 MHz
	always #2.5 clk = ~clk;
	esp_serial_port DUT (.clk(clk), .nrst(nrst), .mode_select_high(msh),
		.address_filter_enable(afe), .rx_enable(rx_en), .double_rate(dbl),
		.bit7_view_select(view), .bit7_wr(b7wr), .bit7_wdata(b7d), .serial_buffer_wr(sb_wr),
		.tx_word(tx_word), .serial_buffer_rd(serial_buffer_rd), .ri_clr(ri_clr),
		.ti_clr(ti_clr), .serial_int_en(1'h1), .timer1_ovf(1'h0), .timer2_ovf(1'h1),
		.timer2_rx_baud_select(t2rx), .timer2_tx_baud_select(t2tx),
		.slave_match_value(smv), .slave_match_mask(smm), .rxd_in(rxd_in),
		.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .rx_word(rx_word),
		.rx_valid(rx_valid), .receive_complete_flag(ri), .transmit_complete_flag(ti),
		.serial_irq(irq), .shared_bit7_position(b7), .timer2_flag_block(t2blk));
	esp_far_end far (.clk(clk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .line(rxd_in));
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic [15:0] rnd(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Bit 7 write; view select is held so later reads see the same flag
	task automatic wr7(input logic v, input logic d);
		view = v;
		b7d = d;
		b7wr = 1'h1;
		tick(1);
		b7wr = 1'h0;
		tick(1);
	endtask
	// Frame from the far end; accepted frames are noted for the watcher
	task automatic rx_frame(input logic [8:0] w, input logic stp, input logic keep);
		if (keep) rxq.push_back(w);
		far.send(w, stp);
		tick(4);
	endtask
	task automatic pulse_clr(input logic which);
		if (which) ti_clr = 1'h1;
		else ri_clr = 1'h1;
		tick(1);
		ti_clr = 1'h0;
		ri_clr = 1'h0;
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Receive watcher pops the buffer; reads can be stalled with rd_en
	always @(negedge clk) begin
		if (serial_buffer_rd) serial_buffer_rd = 1'h0;
		else if (rx_valid === 1'h1 && rd_en) begin
			e = rxq.pop_front();
			`CHK("received word", e, rx_word)
			serial_buffer_rd = 1'h1;
		end
	end
	// Transmit watcher compares each decoded frame with the oldest note
	always @(far.seen) begin
		e10 = txq.pop_front();
		`CHK("sent frame", e10, far.got)
	end
	// Hang guard, far beyond the few thousand cycles the run needs
	initial begin
		#200us;
		num_errors++;
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		tick(16);
		nrst = 1'h1;
		tick(2);
		// Modes 1, 2, 3: send and receive at once, 16 or 32 clocks a bit
		for (int m = 1; m < 4; m++) begin
			msh = m[1];
			wr7(1'h0, m[0]);
			`CHK("mode low bit", m[0], b7)
			rx_en = 1'h1;
			dbl = 1'h1;
			far.bit_clks = (m == 2) ? 32 : 16;
			lfsr = rnd(lfsr);
			tx_word = lfsr[8:0];
			txq.push_back({1'h1, (m == 1) ? 1'h1 : lfsr[8], lfsr[7:0]});
			sb_wr = 1'h1;
			tick(1);
			sb_wr = 1'h0;
			lfsr = rnd(lfsr);
			rx_frame({(m == 1) ? 1'h1 : lfsr[8], lfsr[7:0]}, 1'h1, 1'h1);
			tick(far.bit_clks * 2);
			`CHK("transmit flag", 1'h1, ti)
			`CHK("interrupt", 1'h1, irq)
			pulse_clr(1'h1);
			`CHK("transmit flag cleared", 1'h0, ti)
		end
		// Missing stop bit sets the error flag, which then sticks
		view = 1'h1;
		tick(1);
		`CHK("error flag idle", 1'h0, b7)
		rx_frame(9'h0a5, 1'h0, 1'h1);
		`CHK("error flag set", 1'h1, b7)
		rx_frame(9'h13c, 1'h1, 1'h1);
		wr7(1'h1, 1'h1);
		`CHK("error flag sticky", 1'h1, b7)
		wr7(1'h1, 1'h0);
		`CHK("error flag cleared", 1'h0, b7)
		// Filter on, reads stalled: only given or broadcast addresses land
		rd_en = 1'h0;
		afe = 1'h1;
		smv = 8'h5a;
		smm = 8'hf0;
		tick(2);
		pulse_clr(1'h0);
		rx_frame(9'h113, 1'h1, 1'h0);
		`CHK("flag after foreign address", 1'h0, ri)
		rx_frame(9'h053, 1'h1, 1'h0);
		rx_frame(9'h153, 1'h1, 1'h1);
		`CHK("flag after given address", 1'h1, ri)
		rx_frame(9'h1ff, 1'h1, 1'h1);
		`CHK("buffer holds words", 1'h1, rx_valid)
		afe = 1'h0;
		rd_en = 1'h1;
		tick(10);
		`CHK("buffer drained", 1'h0, rx_valid)
		// Mode 0: shift clock on txd, data both ways on the data pin
		rx_en = 1'h0;
		far.m0 = 1'h1;
		pulse_clr(1'h0);
		msh = 1'h0;
		wr7(1'h0, 1'h0);
		lfsr = rnd(lfsr);
		tx_word = lfsr[8:0];
		sb_wr = 1'h1;
		tick(1);
		sb_wr = 1'h0;
		`CHK("data pin driven", 1'h1, rxd_oe)
		tick(100);
		`CHK("mode 0 byte sent", lfsr[7:0], far.m0_got)
		`CHK("data pin released", 1'h0, rxd_oe)
		`CHK("mode 0 transmit flag", 1'h1, ti)
		lfsr = rnd(lfsr);
		far.m0_out = lfsr[7:0];
		far.m0_left = 8;
		rxq.push_back({1'h0, lfsr[7:0]});
		rx_en = 1'h1;
		tick(110);
		`CHK("mode 0 receive flag", 1'h1, ri)
		`CHK("timer 2 flag block", 1'h1, t2blk)
		t2rx = 1'h0;
		t2tx = 1'h0;
		tick(2);
		`CHK("timer 2 flag free", 1'h0, t2blk)
		`CHK("notes left", 0, rxq.size() + txq.size())
		report_and_stop();
	end
endmodule // esp_serial_port_tb_top
